// [hdl/field_fifo_pkg.sv]
// constants and types shared by the dual field fifo pointer control
package field_fifo_pkg;
	localparam int unsigned DEPTH = 262214;
	localparam int PTR_W = 19;
	localparam int DATA_W = 8;
	localparam int NUM_PORTS = 2;
	localparam int BUF_W = DATA_W + 1;
	localparam logic [PTR_W-1:0] PTR_RST = 19'h00000;
	localparam logic [PTR_W-1:0] PTR_LAST = 19'(DEPTH - 1);
	localparam logic [PTR_W-1:0] PTR_DEPTH = 19'(DEPTH);
	// read lag below this returns the previous series
	localparam logic [PTR_W-1:0] OLD_LAG = 19'h00046;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	localparam logic [BUF_W-1:0] ENTRY_RST = 9'h000;

	typedef logic [PTR_W-1:0] ptr_t;
	typedef logic [DATA_W-1:0] data_t;
	typedef logic [BUF_W-1:0] entry_t;

	typedef enum logic [1:0] {
		BUF_EMPTY = 2'b00,
		BUF_ONE = 2'b01,
		BUF_TWO = 2'b10
	} buf_fill_t;
endpackage

// [hdl/fifo_links_if.sv]
// memory port and word stream interfaces between the fifo modules
`timescale 1ns/1ps
interface mem_port_if;
	import field_fifo_pkg::*;
	logic wr_en;
	ptr_t wr_ptr;
	ptr_t wr_addr;
	data_t wr_data;
	logic rd_en;
	ptr_t rd_addr;
	data_t rd_data;
	modport ctrl(output wr_en, output wr_ptr, output wr_addr, output wr_data, output rd_en,
		output rd_addr, input rd_data);
	modport store(input wr_en, input wr_ptr, input wr_addr, input wr_data, input rd_en,
		input rd_addr, output rd_data);
endinterface

interface word_stream_if;
	import field_fifo_pkg::*;
	logic valid;
	logic ready;
	entry_t data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// [hdl/field_store.sv]
// one port's field memory with registered read
`timescale 1ns/1ps
module field_store (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	mem_port_if.store mp
);
	import field_fifo_pkg::*;

	typedef struct packed {
		data_t rd_data;
	} store_st_t;

	data_t mem [0:DEPTH-1];
	data_t old_mem [0:DEPTH-1];
	store_st_t st_r;
	store_st_t st_nxt;
	ptr_t lag;
	logic old_pick;

	// distance of the read behind the write pointer, modulo the field
	assign lag = (mp.wr_ptr >= mp.rd_addr) ? (mp.wr_ptr - mp.rd_addr) :
		(PTR_DEPTH - (mp.rd_addr - mp.wr_ptr));
	assign old_pick = (lag < OLD_LAG);

	always_comb begin
		st_nxt = st_r;
		if (mp.rd_en) begin
			st_nxt.rd_data = old_pick ? old_mem[mp.rd_addr] : mem[mp.rd_addr];
		end
	end

	// each write keeps the word it replaces as the previous series
	always_ff @(posedge clk) begin
		if (ce && mp.wr_en) begin
			old_mem[mp.wr_addr] <= mem[mp.wr_addr];
			mem[mp.wr_addr] <= mp.wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{rd_data: DATA_RST};
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign mp.rd_data = st_r.rd_data;
endmodule // field_store

// [hdl/two_entry_buf.sv]
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module two_entry_buf (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	word_stream_if.snk in_s,
	word_stream_if.src out_s
);
	import field_fifo_pkg::*;

	typedef struct packed {
		buf_fill_t fill;
		entry_t e0;
		entry_t e1;
	} buf_st_t;

	buf_st_t st_r;
	buf_st_t st_nxt;
	logic push;
	logic pop;

	assign in_s.ready = (st_r.fill != BUF_TWO);
	assign out_s.valid = (st_r.fill != BUF_EMPTY);
	assign out_s.data = st_r.e0;
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;

	always_comb begin
		st_nxt = st_r;
		unique case (st_r.fill)
			BUF_EMPTY: begin
				if (push) begin
					st_nxt.e0 = in_s.data;
					st_nxt.fill = BUF_ONE;
				end
			end
			BUF_ONE: begin
				if (push && pop) begin
					st_nxt.e0 = in_s.data;
				end else if (push) begin
					st_nxt.e1 = in_s.data;
					st_nxt.fill = BUF_TWO;
				end else if (pop) begin
					st_nxt.fill = BUF_EMPTY;
				end
			end
			BUF_TWO: begin
				if (pop) begin
					st_nxt.e0 = st_r.e1;
					st_nxt.fill = BUF_ONE;
				end
			end
			default: begin
				st_nxt.fill = BUF_EMPTY;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{fill: BUF_EMPTY, e0: ENTRY_RST, e1: ENTRY_RST};
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end
endmodule // two_entry_buf

// [hdl/dual_field_fifo_ptr_ctrl.sv]
// pointer and port control of the dual-port serial field fifo
// Notes on behaviour
// - first read clock rise with port-1 read clear high zeroes port-1 read pointer.
// - port-1 read clear cycle ignores read gate and output drive.
// - read gate high at read clock rise advances that read pointer if the output buffer has room.
// - read gate low at read clock rise leaves that read pointer.
// - output drive enables or disables outputs; pointer advance ignores it.
// - port-1 write stores when gate and mask high; gate alone advances pointer.
// - port-2 write stores when gate and mask high; gate alone advances pointer.
// - each gated read clock rise with output buffer room shifts a stored word out.
// - outputs three-state, same polarity as written, valid after each read.
// - first port-2 write clock rise with write clear high zeroes its pointer.
// - port-2 write clear cycle ignores write gate and write mask.
// - port-2 write gate low blocks input and freezes write pointer.
// - gate levels may last any time; state is held statically.
// - port-2 write pointer advances regardless of mask; mask high writes memory.
// - port-2 read clear cycle zeroes pointer, ignores gate and drive.
// - cascade select low starts access in the cycle of the controls.
// - cascade select high starts access one cycle after the controls.
// - read trailing write by under 70 returns previous series data.
`timescale 1ns/1ps
module dual_field_fifo_ptr_ctrl (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic cascade_sel,
	input wire logic wr_clk_p1,
	input wire logic wr_clk_p2,
	input wire logic wr_ptr_clear_p1,
	input wire logic wr_ptr_clear_p2,
	input wire logic wr_gate_p1,
	input wire logic wr_gate_p2,
	input wire logic wr_mask_p1,
	input wire logic wr_mask_p2,
	input wire field_fifo_pkg::data_t din_p1,
	input wire field_fifo_pkg::data_t din_p2,
	input wire logic shared_rd_clk,
	input wire logic rd_ptr_clear_p1,
	input wire logic rd_ptr_clear_p2,
	input wire logic rd_gate_p1,
	input wire logic rd_gate_p2,
	input wire logic out_drive_p1,
	input wire logic out_drive_p2,
	input wire logic out_ready_p1,
	input wire logic out_ready_p2,
	output field_fifo_pkg::data_t dout_p1,
	output field_fifo_pkg::data_t dout_p2,
	output logic dout_oe_p1,
	output logic dout_oe_p2,
	output logic dout_valid_p1,
	output logic dout_valid_p2,
	output logic rd_ready_p1,
	output logic rd_ready_p2
);
	import field_fifo_pkg::*;

	// controls seen at one sampled clock rise
	typedef struct packed {
		logic wr_evt;
		logic wr_clr;
		logic wr_gate;
		logic wr_mask;
		data_t din;
		logic rd_evt;
		logic rd_clr;
		logic rd_gate;
		logic rd_drive;
	} ctl_ev_t;

	typedef struct packed {
		ptr_t wr_ptr;
		ptr_t rd_ptr;
		logic rd_pend;
		logic pend_drive;
		ctl_ev_t ev_d;
		data_t dout;
		logic doe;
		logic dvalid;
		logic rd_ready;
	} port_st_t;

	typedef struct packed {
		logic [NUM_PORTS-1:0] wr_clk_prev;
		logic rd_clk_prev;
		port_st_t [NUM_PORTS-1:0] p;
	} top_st_t;

	top_st_t st_r;
	top_st_t st_nxt;

	logic [NUM_PORTS-1:0] wr_clk_in;
	logic [NUM_PORTS-1:0] wr_clr_in;
	logic [NUM_PORTS-1:0] wr_gate_in;
	logic [NUM_PORTS-1:0] wr_mask_in;
	data_t [NUM_PORTS-1:0] din_in;
	logic [NUM_PORTS-1:0] rd_clr_in;
	logic [NUM_PORTS-1:0] rd_gate_in;
	logic [NUM_PORTS-1:0] rd_drive_in;
	logic [NUM_PORTS-1:0] out_ready_in;

	logic [NUM_PORTS-1:0] mem_wr_en;
	ptr_t [NUM_PORTS-1:0] mem_wr_addr;
	data_t [NUM_PORTS-1:0] mem_wr_data;
	logic [NUM_PORTS-1:0] mem_rd_en;
	ptr_t [NUM_PORTS-1:0] mem_rd_addr;
	data_t [NUM_PORTS-1:0] mem_rd_data;
	logic [NUM_PORTS-1:0] buf_in_ready;
	logic [NUM_PORTS-1:0] buf_out_valid;
	entry_t [NUM_PORTS-1:0] buf_out_data;
	logic [NUM_PORTS-1:0] buf_out_ready;

	assign wr_clk_in = {wr_clk_p2, wr_clk_p1};
	assign wr_clr_in = {wr_ptr_clear_p2, wr_ptr_clear_p1};
	assign wr_gate_in = {wr_gate_p2, wr_gate_p1};
	assign wr_mask_in = {wr_mask_p2, wr_mask_p1};
	assign din_in = {din_p2, din_p1};
	assign rd_clr_in = {rd_ptr_clear_p2, rd_ptr_clear_p1};
	assign rd_gate_in = {rd_gate_p2, rd_gate_p1};
	assign rd_drive_in = {out_drive_p2, out_drive_p1};
	assign out_ready_in = {out_ready_p2, out_ready_p1};

	// per-port memory and output buffer
	for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
		mem_port_if mp ();
		word_stream_if rd_in ();
		word_stream_if rd_out ();

		assign mp.wr_en = mem_wr_en[g];
		assign mp.wr_ptr = st_r.p[g].wr_ptr;
		assign mp.wr_addr = mem_wr_addr[g];
		assign mp.wr_data = mem_wr_data[g];
		assign mp.rd_en = mem_rd_en[g];
		assign mp.rd_addr = mem_rd_addr[g];
		assign mem_rd_data[g] = mp.rd_data;

		// word read last cycle enters the buffer with its drive flag
		assign rd_in.valid = st_r.p[g].rd_pend;
		assign rd_in.data = {st_r.p[g].pend_drive, mem_rd_data[g]};
		assign buf_in_ready[g] = rd_in.ready;
		assign buf_out_valid[g] = rd_out.valid;
		assign buf_out_data[g] = rd_out.data;
		assign rd_out.ready = buf_out_ready[g];

		field_store u_store (
			.clk(clk),
			.rst_n(rst_n),
			.ce(ce),
			.mp(mp.store)
		);

		two_entry_buf u_buf (
			.clk(clk),
			.rst_n(rst_n),
			.ce(ce),
			.in_s(rd_in.snk),
			.out_s(rd_out.src)
		);
	end

	always_comb begin
		ctl_ev_t ev_now;
		ctl_ev_t ev;
		logic rd_rise;
		st_nxt = st_r;
		ev_now = '0;
		ev = '0;
		rd_rise = shared_rd_clk && !st_r.rd_clk_prev;
		st_nxt.wr_clk_prev = wr_clk_in;
		st_nxt.rd_clk_prev = shared_rd_clk;
		mem_wr_en = '0;
		mem_wr_addr = '0;
		mem_wr_data = '0;
		mem_rd_en = '0;
		mem_rd_addr = '0;
		buf_out_ready = '0;
		for (int i = 0; i < NUM_PORTS; i++) begin
			ev_now.wr_evt = wr_clk_in[i] && !st_r.wr_clk_prev[i];
			ev_now.wr_clr = wr_clr_in[i];
			ev_now.wr_gate = wr_gate_in[i];
			ev_now.wr_mask = wr_mask_in[i];
			ev_now.din = din_in[i];
			ev_now.rd_evt = rd_rise;
			ev_now.rd_clr = rd_clr_in[i];
			ev_now.rd_gate = rd_gate_in[i];
			ev_now.rd_drive = rd_drive_in[i];
			st_nxt.p[i].ev_d = ev_now;
			// cascade delays the access by one cycle
			ev = cascade_sel ? st_r.p[i].ev_d : ev_now;

			// write side
			if (ev.wr_evt) begin
				if (ev.wr_clr) begin
					st_nxt.p[i].wr_ptr = PTR_RST;
				end else if (ev.wr_gate) begin
					mem_wr_en[i] = ev.wr_mask;
					mem_wr_addr[i] = st_r.p[i].wr_ptr;
					mem_wr_data[i] = ev.din;
					st_nxt.p[i].wr_ptr = (st_r.p[i].wr_ptr == PTR_LAST) ?
						PTR_RST : st_r.p[i].wr_ptr + 19'h00001;
				end
				// gate low holds pointer and blocks input, for any length
			end

			// read side
			st_nxt.p[i].rd_pend = 1'b0;
			if (ev.rd_evt) begin
				if (ev.rd_clr) begin
					st_nxt.p[i].rd_ptr = PTR_RST;
				end else if (ev.rd_gate && buf_in_ready[i]) begin
					mem_rd_en[i] = 1'b1;
					mem_rd_addr[i] = st_r.p[i].rd_ptr;
					st_nxt.p[i].rd_pend = 1'b1;
					st_nxt.p[i].pend_drive = ev.rd_drive;
					st_nxt.p[i].rd_ptr = (st_r.p[i].rd_ptr == PTR_LAST) ?
						PTR_RST : st_r.p[i].rd_ptr + 19'h00001;
				end
				// gate low leaves the read pointer
			end

			// output stage drains the buffer when the receiver is ready
			st_nxt.p[i].dvalid = 1'b0;
			if (buf_out_valid[i] && out_ready_in[i]) begin
				buf_out_ready[i] = 1'b1;
				st_nxt.p[i].dout = buf_out_data[i][DATA_W-1:0];
				st_nxt.p[i].doe = buf_out_data[i][DATA_W];
				st_nxt.p[i].dvalid = 1'b1;
			end
			st_nxt.p[i].rd_ready = buf_in_ready[i];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	assign dout_p1 = st_r.p[0].dout;
	assign dout_p2 = st_r.p[1].dout;
	assign dout_oe_p1 = st_r.p[0].doe;
	assign dout_oe_p2 = st_r.p[1].doe;
	assign dout_valid_p1 = st_r.p[0].dvalid;
	assign dout_valid_p2 = st_r.p[1].dvalid;
	assign rd_ready_p1 = st_r.p[0].rd_ready;
	assign rd_ready_p2 = st_r.p[1].rd_ready;
endmodule // dual_field_fifo_ptr_ctrl

// [dv/fifo_ctrl_chk_sva.sv]
// port checker for the field fifo pointer control
`timescale 1ns/1ps
module fifo_ctrl_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cascade_sel,
	input wire logic shared_rd_clk,
	input wire logic rd_ptr_clear_p1,
	input wire logic rd_ptr_clear_p2,
	input wire logic rd_gate_p1,
	input wire logic out_drive_p1,
	input wire logic out_ready_p1,
	input wire logic out_ready_p2,
	input wire logic rd_ready_p1,
	input wire field_fifo_pkg::data_t dout_p1,
	input wire logic dout_oe_p1,
	input wire logic dout_valid_p1,
	input wire logic dout_valid_p2
);
	import field_fifo_pkg::*;
	logic rd_q_r;
	logic rise;
	logic tk;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) rd_q_r <= 1'b0;
		else rd_q_r <= shared_rd_clk;
	end
	assign rise = shared_rd_clk & !rd_q_r;
	assign tk = rise & rd_gate_p1 & !rd_ptr_clear_p1 & rd_ready_p1;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_read_latency: assert property (
		tk && !cascade_sel && out_ready_p1 ##1 out_ready_p1[*2] |-> !dout_valid_p1 ##1 dout_valid_p1)
		else $error("word late or early");
	chk_drive_flag: assert property (
		tk && !cascade_sel && out_ready_p1 ##1 out_ready_p1[*2] |=> dout_oe_p1 == $past(out_drive_p1, 3))
		else $error("drive flag lost");
	chk_cascade_wait: assert property (
		tk && cascade_sel && out_ready_p1 ##1 out_ready_p1[*3] |-> !dout_valid_p1 ##1 dout_valid_p1)
		else $error("cascade latency wrong");
	chk_clear_p1_quiet: assert property (
		rise && rd_ptr_clear_p1 && !cascade_sel && out_ready_p1 ##1 out_ready_p1[*2] |=> !dout_valid_p1)
		else $error("clear gave a word");
	chk_clear_p2_quiet: assert property (
		rise && rd_ptr_clear_p2 && !cascade_sel && out_ready_p2 ##1 out_ready_p2[*2] |=> !dout_valid_p2)
		else $error("clear gave a word");
	chk_gate_low_quiet: assert property (
		rise && !rd_gate_p1 && !cascade_sel && out_ready_p1 ##1 out_ready_p1[*2] |=> !dout_valid_p1)
		else $error("ungated read gave a word");
	chk_word_holds: assert property (
		!dout_valid_p1 |-> $stable(dout_p1) && $stable(dout_oe_p1))
		else $error("output moved without a word");
	chk_ready_drain: assert property (
		dout_valid_p2 |-> $past(out_ready_p2))
		else $error("word given to a stalled receiver");
	cover property (tk && cascade_sel);
	cover property (rise && rd_ptr_clear_p2);
	cover property (dout_valid_p1 && !dout_oe_p1);
endmodule // fifo_ctrl_chk
bind dual_field_fifo_ptr_ctrl fifo_ctrl_chk chk (.*);

// [dv/word_sink.sv]
// receiving side model collecting delivered words
`timescale 1ns/1ps
module word_sink (
	input wire logic clk,
	input wire logic dout_valid_p1,
	input wire logic dout_valid_p2,
	input wire logic dout_oe_p1,
	input wire logic dout_oe_p2,
	input wire field_fifo_pkg::data_t dout_p1,
	input wire field_fifo_pkg::data_t dout_p2,
	output logic out_ready_p1,
	output logic out_ready_p2
);
	import field_fifo_pkg::*;
	logic [1:0] stall = 2'b00;
	entry_t q1[$];
	entry_t q2[$];
	assign out_ready_p1 = !stall[0];
	assign out_ready_p2 = !stall[1];
	// a word exists only in the one cycle its pulse stands
	always @(posedge clk) begin
		if (dout_valid_p1 === 1'b1) q1.push_back({dout_oe_p1, dout_p1});
		if (dout_valid_p2 === 1'b1) q2.push_back({dout_oe_p2, dout_p2});
	end
endmodule // word_sink

// [dv/test_dual_field_fifo_ptr_ctrl.sv]
// self-checking bench of the field fifo pointer control
`timescale 1ns/1ps
`define CHK(w, e, s) begin \
	n_checks++; \
	if ((s) !== (e)) begin \
		fails++; \
		$display("BAD %s exp %h got %h", w, e, s); \
	end \
end
module test_dual_field_fifo_ptr_ctrl;
	import field_fifo_pkg::*;
	logic clk = 0, rst_n = 0, ce = 1, cascade_sel = 0;
	logic wr_clk_p1 = 0, wr_clk_p2 = 0, wr_ptr_clear_p1 = 0, wr_ptr_clear_p2 = 0;
	logic wr_gate_p1 = 0, wr_gate_p2 = 0, wr_mask_p1 = 0, wr_mask_p2 = 0;
	data_t din_p1 = 8'h00, din_p2 = 8'h00, dout_p1, dout_p2;
	logic shared_rd_clk = 0, rd_ptr_clear_p1 = 0, rd_ptr_clear_p2 = 0;
	logic rd_gate_p1 = 0, rd_gate_p2 = 0, out_drive_p1 = 0, out_drive_p2 = 0;
	logic out_ready_p1, out_ready_p2, dout_oe_p1, dout_oe_p2;
	logic dout_valid_p1, dout_valid_p2, rd_ready_p1, rd_ready_p2;
	int fails = 0, n_checks = 0;
	always #25 clk = ~clk;
	dual_field_fifo_ptr_ctrl DUT (.*);
	word_sink sink (.*);
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic do_reset(input logic cas);
		@(negedge clk);
		rst_n = 0;
		cascade_sel = cas;
		sink.q1.delete();
		sink.q2.delete();
		repeat (8) @(negedge clk);
		rst_n = 1;
	endtask
	// one write clock rise, rises two clocks apart
	task automatic wclk(input bit p, input logic [2:0] gmc, input data_t d);
		@(negedge clk);
		if (p) {wr_gate_p2, wr_mask_p2, wr_ptr_clear_p2, din_p2, wr_clk_p2} = {gmc, d, 1'b1};
		else {wr_gate_p1, wr_mask_p1, wr_ptr_clear_p1, din_p1, wr_clk_p1} = {gmc, d, 1'b1};
		@(negedge clk);
		wr_clk_p1 = 0;
		wr_clk_p2 = 0;
	endtask
	// mask-low write rises move the write pointer 600 ahead of reads
	task automatic pad(input bit p);
		repeat (600) wclk(p, 3'b100, 8'h00);
	endtask
	task automatic rclk(input logic [1:0] g, c, o);
		@(negedge clk);
		{rd_gate_p2, rd_gate_p1, rd_ptr_clear_p2, rd_ptr_clear_p1} = {g, c};
		{out_drive_p2, out_drive_p1, shared_rd_clk} = {o, 1'b1};
		@(negedge clk);
		shared_rd_clk = 0;
	endtask
	task automatic t_series();
		logic [1:0] o[4] = '{2'b11, 2'b00, 2'b11, 2'b01};
		data_t d[4] = '{8'h20, 8'h11, 8'h23, 8'h13};
		data_t b;
		for (int p = 0; p < 2; p++) begin
			b = 8'(p * 64);
			wclk(p[0], 3'b111, 8'hff);
			for (int i = 0; i < 4; i++) wclk(p[0], 3'b110, b + 8'h10 + 8'(i));
			wclk(p[0], 3'b111, 8'hff);
			wclk(p[0], 3'b110, b + 8'h20);
			wclk(p[0], 3'b100, b + 8'h21);
			wclk(p[0], 3'b010, b + 8'h22);
			wclk(p[0], 3'b110, b + 8'h23);
		end
		rclk(2'b11, 2'b11, 2'b11);
		rclk(2'b11, 2'b00, 2'b11);
		rclk(2'b00, 2'b00, 2'b11);
		for (int p = 0; p < 2; p++) pad(p[0]);
		`CHK("old p1", {1'b1, 8'h10}, sink.q1[0])
		`CHK("old p2", {1'b1, 8'h50}, sink.q2[0])
		sink.q1.delete();
		sink.q2.delete();
		rclk(2'b11, 2'b11, 2'b11);
		for (int i = 0; i < 4; i++) begin
			rclk(2'b11, 2'b00, o[i]);
			rclk(2'b00, 2'b00, 2'b11);
		end
		repeat (8) @(negedge clk);
		`CHK("count p1", 4, sink.q1.size())
		`CHK("count p2", 4, sink.q2.size())
		for (int i = 0; i < 4; i++) begin
			`CHK("word p1", {o[i][0], d[i]}, sink.q1[i])
			`CHK("word p2", {o[i][1], d[i] + 8'h40}, sink.q2[i])
		end
		sink.q1.delete();
		sink.q2.delete();
		$display("series test done");
	endtask
	task automatic t_stall();
		int k;
		wclk(1'b1, 3'b111, 8'hff);
		for (int i = 0; i < 6; i++) wclk(1'b1, 3'b110, 8'h30 + 8'(i));
		pad(1'b1);
		rclk(2'b10, 2'b10, 2'b00);
		sink.stall = 2'b10;
		repeat (6) rclk(2'b10, 2'b00, 2'b10);
		`CHK("room p2", 1'b0, rd_ready_p2)
		sink.stall = 2'b00;
		k = 0;
		while (sink.q2.size() < 6 && k < 20) begin
			rclk(2'b10, 2'b00, 2'b10);
			k++;
		end
		repeat (8) @(negedge clk);
		`CHK("enough p2", 1'b1, sink.q2.size() >= 6)
		for (int i = 0; i < 6; i++) `CHK("held p2", {1'b1, 8'h30 + 8'(i)}, sink.q2[i])
		$display("stall test done");
	endtask
	initial begin
		do_reset(1'b0);
		t_series();
		t_stall();
		do_reset(1'b1);
		t_series();
		complete_run();
	end
	initial begin
		#(50 * 20000);
		fails++;
		complete_run();
	end
endmodule // test_dual_field_fifo_ptr_ctrl
